// ---- acr_pkg.sv ----
package acr_pkg;

   // Register selection and reset image
   localparam logic [1:0]  ACR_CFG_POINTER   = 2'h1;
   localparam logic [15:0] ACR_CFG_RESET     = 16'h058B;
   // Bits that a qualified write really stores
   localparam logic [15:0] ACR_CFG_WR_MASK   = 16'h7FE8;
   // Bits forced in the readback: qualifier 01 and bit 0 at 1
   localparam logic [15:0] ACR_CFG_FIXED_ONE = 16'h0003;

   // Field positions
   localparam int ACR_TRIG_BIT    = 15;
   localparam int ACR_MUX_MSB     = 14;
   localparam int ACR_MUX_LSB     = 12;
   localparam int ACR_RANGE_MSB   = 11;
   localparam int ACR_RANGE_LSB   = 9;
   localparam int ACR_MODE_BIT    = 8;
   localparam int ACR_RATE_MSB    = 7;
   localparam int ACR_RATE_LSB    = 5;
   localparam int ACR_PULLUP_BIT  = 3;
   localparam int ACR_QUAL_MSB    = 2;
   localparam int ACR_QUAL_LSB    = 1;

   // Qualifier code that commits a write
   localparam logic [1:0]  ACR_QUAL_COMMIT   = 2'b01;

   // Frame lengths in serial clock periods
   localparam logic [5:0]  ACR_WORD_BITS     = 6'h10;
   localparam logic [5:0]  ACR_FRAME_BITS    = 6'h20;

   // Input pair selection codes
   localparam logic [2:0]  ACR_MUX_P0_N1     = 3'h0;
   localparam logic [2:0]  ACR_MUX_P0_N3     = 3'h1;
   localparam logic [2:0]  ACR_MUX_P1_N3     = 3'h2;
   localparam logic [2:0]  ACR_MUX_P2_N3     = 3'h3;

   // Conversion sequencer states
   typedef enum logic [2:0] {
      ACR_ST_DOWN   = 3'b001,
      ACR_ST_SINGLE = 3'b010,
      ACR_ST_CONT   = 3'b100
   } acr_state_t;

endpackage : acr_pkg

// ---- acr_adc_config.sv ----
// Function
// - A committed word with the trigger bit at 1 while powered down starts exactly one conversion; 0 does nothing.
// - A trigger written while a conversion is running is ignored and the conversion goes on.
// - The trigger bit always reads back as 0.
// - Input select codes 000 to 011 choose the pairs 0-1, 0-3, 1-3 and 2-3.
// - Input select codes 100 to 111 choose inputs 0 to 3 against ground, and the field resets to 000.
// - The range field picks the full-scale span from code 000 to 110 and resets to 010.
// - Mode 0 runs continuous conversion, mode 1 powers down with single-shot operation, reset 1.
// - The rate field picks 6.25 to 1000 samples per second and resets to 100.
// - Reserved bits 4 and 0 ignore writes; bit 4 resets to 0 and bit 0 always reads 1.
// - With chip select high the pull-up bit at 1 ties on the weak pull-up, at 0 the pin floats.
// - The register is updated only when the incoming qualifier field is 01.
// - The configuration register, pointer 1, resets to 058Bh.
// - The serial input is sampled on the falling serial clock edge and is never driven.
// - In a 32-bit frame the register value in force after the first half returns in the second half, MSB first.
// - The register is written on the serial input while the result shifts out on the data output.
module acr_adc_config (
   input  wire logic                  clk_i,                 // System clock, 100 MHz
   input  wire logic                  rst_i,                 // Synchronous reset, active high
   input  wire logic                  cs_n_i,                // Chip select pin, active low
   input  wire logic                  sclk_i,                // Serial clock pin
   input  wire logic                  din_i,                 // Serial data input pin
   output logic                       serial_out_ready_n_o,  // Data out / ready level, ready low
   output logic                       serial_out_oe_o,       // Drive enable for data out pin
   output logic                       pullup_en_o,           // Weak pull-up connect on data out
   input  wire logic                  conv_done_i,           // Conversion finished pulse
   input  wire logic [15:0]           conv_data_i,           // Result of finished conversion
   output logic                       conv_start_o,          // Start one conversion pulse
   output logic                       continuous_o,          // Continuous mode active
   output logic                       powered_down_o,        // Converter idle in power-down
   output logic [1:0]                 positive_input_sel_o,  // Positive input number
   output logic [1:0]                 negative_input_sel_o,  // Negative input number
   output logic                       negative_is_ground_o,  // Negative input tied to ground
   output logic [2:0]                 range_select_o,        // Full-scale span code
   output logic [2:0]                 rate_select_o          // Output rate code
);
   import acr_pkg::*;

   logic [2:0]  cs_sync_q;
   logic [2:0]  sclk_sync_q;
   logic [1:0]  din_sync_q;
   logic        cs_low;
   logic        cs_fall;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [5:0]  bit_cnt_q;
   logic        started_q;
   logic [15:0] rx_q;
   logic [15:0] word_next;
   logic        word_done;
   logic        commit;
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;
   logic [15:0] readback;
   logic [31:0] tx_q;
   logic [15:0] conv_buf_q;
   logic        ready_n_q;
   logic        trigger;
   acr_state_t  state_q;

   // Pins cross into the clock domain; edges seen only past stage two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_sync_q   <= 3'b111;
         sclk_sync_q <= 3'b000;
         din_sync_q  <= 2'b00;
      end else begin
         cs_sync_q   <= {cs_sync_q[1:0], cs_n_i};
         sclk_sync_q <= {sclk_sync_q[1:0], sclk_i};
         din_sync_q  <= {din_sync_q[0], din_i};
      end
   end

   assign cs_low    = ~cs_sync_q[1];
   assign cs_fall   = cs_sync_q[2] & ~cs_sync_q[1];
   assign sclk_rise = cs_low & sclk_sync_q[1] & ~sclk_sync_q[2];
   assign sclk_fall = cs_low & ~sclk_sync_q[1] & sclk_sync_q[2];

   // Completed word and its qualifier check
   assign word_next = {rx_q[14:0], din_sync_q[1]};
   assign word_done = sclk_fall & (bit_cnt_q == ACR_WORD_BITS - 6'h01);
   assign commit    = word_done & (word_next[ACR_QUAL_MSB:ACR_QUAL_LSB] == ACR_QUAL_COMMIT);

   // Stored value only keeps writable bits; reserved bit 4 stays 0
   // reserved bits masked
   assign cfg_d     = word_next & ACR_CFG_WR_MASK;

   // Readback of the value in force after this word
   // trigger reads zero
   assign readback  = (commit ? cfg_d : cfg_q) | ACR_CFG_FIXED_ONE;

   // Trigger honoured only from power-down
   // one start from idle
   assign trigger   = commit & word_next[ACR_TRIG_BIT] & (state_q == ACR_ST_DOWN);

   // Bit counter, falling edges within a frame; wraps after 32
   // sample on falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i || !cs_low) begin
         bit_cnt_q <= 6'h00;
      end else if (sclk_fall) begin
         if (bit_cnt_q == ACR_FRAME_BITS - 6'h01) begin
            bit_cnt_q <= 6'h00;
         end else begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end
   end

   // Receive shift register, first word of the frame only
   // write during readout
   always_ff @(posedge clk_i) begin
      if (rst_i || !cs_low) begin
         rx_q <= 16'h0000;
      end else if (sclk_fall && bit_cnt_q < ACR_WORD_BITS) begin
         rx_q <= word_next;
      end
   end

   // Configuration register, all fields change on the same edge
   // reset value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= ACR_CFG_RESET & ACR_CFG_WR_MASK;
      end else if (commit) begin
         cfg_q <= cfg_d;
      end
   end

   // Result buffer; a frame copies it at chip select, so a late result cannot tear it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_buf_q <= 16'h0000;
      end else if (conv_done_i) begin
         conv_buf_q <= conv_data_i;
      end
   end

   // New-data flag, low when unread; a fresh result beats the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_n_q <= 1'b1;
      end else if (conv_done_i) begin
         ready_n_q <= 1'b0;
      end else if (sclk_rise && !started_q && bit_cnt_q == 6'h00) begin
         ready_n_q <= 1'b1;
      end
   end

   // Marks that the first rising edge of this frame has passed
   always_ff @(posedge clk_i) begin
      if (rst_i || !cs_low) begin
         started_q <= 1'b0;
      end else if (sclk_fall && bit_cnt_q == ACR_FRAME_BITS - 6'h01) begin
         started_q <= 1'b0;
      end else if (sclk_rise) begin
         started_q <= 1'b1;
      end
   end

   // Transmit shift register: result first, then the readback word
   // readback in second half
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q <= 32'h0000_0000;
      end else if (cs_fall) begin
         tx_q <= {conv_buf_q, 16'h0000};
      end else if (word_done) begin
         tx_q <= {readback, 16'h0000};
      end else if (sclk_fall && bit_cnt_q == ACR_FRAME_BITS - 6'h01) begin
         tx_q <= {conv_buf_q, 16'h0000};
      end else if (sclk_rise) begin
         tx_q <= {tx_q[30:0], 1'b0};
      end
   end

   // Data out pin: ready level before the first rising edge, then data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_ready_n_o <= 1'b1;
      end else if (!cs_low) begin
         serial_out_ready_n_o <= 1'b1;
      end else if (sclk_rise) begin
         serial_out_ready_n_o <= tx_q[31];
      end else if (!started_q) begin
         serial_out_ready_n_o <= ready_n_q;
      end
   end

   // Pin drive and pull-up; the input pin has no driver at all
   // pull-up with chip select high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_oe_o <= 1'b0;
         pullup_en_o     <= 1'b1;
      end else begin
         serial_out_oe_o <= cs_low;
         pullup_en_o     <= ~cs_low & cfg_q[ACR_PULLUP_BIT];
      end
   end

   // Conversion sequencer
   // mode selects sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q      <= ACR_ST_DOWN;
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         case (state_q)
            ACR_ST_DOWN: begin
               if (!cfg_q[ACR_MODE_BIT]) begin
                  state_q      <= ACR_ST_CONT;
                  conv_start_o <= 1'b1;
               end else if (trigger) begin
                  state_q      <= ACR_ST_SINGLE;
                  conv_start_o <= 1'b1;
               end
            end
            ACR_ST_SINGLE: begin
               if (conv_done_i) begin
                  state_q <= ACR_ST_DOWN;
               end
            end
            ACR_ST_CONT: begin
               if (conv_done_i) begin
                  if (cfg_q[ACR_MODE_BIT]) begin
                     state_q <= ACR_ST_DOWN;
                  end else begin
                     conv_start_o <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= ACR_ST_DOWN;
            end
         endcase
      end
   end

   // Status outputs follow the sequencer one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         continuous_o   <= 1'b0;
         powered_down_o <= 1'b1;
      end else begin
         continuous_o   <= (state_q == ACR_ST_CONT);
         powered_down_o <= (state_q == ACR_ST_DOWN);
      end
   end

   // Span and rate codes pass to the front end unchanged
   // range field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         range_select_o <= ACR_CFG_RESET[ACR_RANGE_MSB:ACR_RANGE_LSB];
         rate_select_o  <= ACR_CFG_RESET[ACR_RATE_MSB:ACR_RATE_LSB];
      end else begin
         range_select_o <= cfg_q[ACR_RANGE_MSB:ACR_RANGE_LSB];
         rate_select_o  <= cfg_q[ACR_RATE_MSB:ACR_RATE_LSB];
      end
   end

   // Input multiplexer decode
   // differential pairs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         positive_input_sel_o <= 2'h0;
         negative_input_sel_o <= 2'h1;
         negative_is_ground_o <= 1'b0;
      end else begin
         case (cfg_q[ACR_MUX_MSB:ACR_MUX_LSB])
            ACR_MUX_P0_N1: begin
               positive_input_sel_o <= 2'h0;
               negative_input_sel_o <= 2'h1;
               negative_is_ground_o <= 1'b0;
            end
            ACR_MUX_P0_N3: begin
               positive_input_sel_o <= 2'h0;
               negative_input_sel_o <= 2'h3;
               negative_is_ground_o <= 1'b0;
            end
            ACR_MUX_P1_N3: begin
               positive_input_sel_o <= 2'h1;
               negative_input_sel_o <= 2'h3;
               negative_is_ground_o <= 1'b0;
            end
            ACR_MUX_P2_N3: begin
               positive_input_sel_o <= 2'h2;
               negative_input_sel_o <= 2'h3;
               negative_is_ground_o <= 1'b0;
            end
            default: begin
               // Codes 100..111: low two bits name the input
               positive_input_sel_o <= cfg_q[ACR_MUX_LSB+1:ACR_MUX_LSB];
               negative_input_sel_o <= 2'h0;
               negative_is_ground_o <= 1'b1;
            end
         endcase
      end
   end

endmodule // acr_adc_config

// ---- acr_adc_config_chk.sv ----
module acr_adc_config_chk (
   input wire logic       clk_i,                 // Clock
   input wire logic       rst_i,                 // Reset
   input wire logic       cs_n_i,                // Select pin
   input wire logic       serial_out_ready_n_o,  // Data out
   input wire logic       serial_out_oe_o,       // Data out enable
   input wire logic       pullup_en_o,           // Pull-up
   input wire logic       conv_done_i,           // Done pulse
   input wire logic       conv_start_o,          // Start pulse
   input wire logic       continuous_o,          // Continuous
   input wire logic       powered_down_o,        // Idle
   input wire logic [1:0] positive_input_sel_o,  // Positive input
   input wire logic [1:0] negative_input_sel_o,  // Negative input
   input wire logic       negative_is_ground_o,  // Ground negative
   input wire logic [2:0] range_select_o,        // Span code
   input wire logic [2:0] rate_select_o          // Rate code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin sync adds up to three cycles, hence the repeat counts
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_pullup_sel: assert property (!cs_n_i[*4] |-> !pullup_en_o)
      else $error("pull-up on while selected");
   chk_idle_release: assert property (cs_n_i[*4] |-> !serial_out_oe_o && serial_out_ready_n_o)
      else $error("data out driven while deselected");
   chk_drive_sel: assert property (!cs_n_i[*4] |-> serial_out_oe_o)
      else $error("data out not driven while selected");
   chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
      else $error("start longer than one cycle");
   chk_start_wakes: assert property (conv_start_o && !continuous_o |-> ##[1:2] !powered_down_o)
      else $error("start without leaving idle");
   chk_busy_no_start: assert property (!powered_down_o && !continuous_o |-> !conv_start_o)
      else $error("second start while busy");
   chk_done_sleeps: assert property (conv_done_i && !continuous_o |-> ##[1:3] powered_down_o)
      else $error("no return to idle after single conversion");
   chk_ground_neg: assert property (negative_is_ground_o |-> negative_input_sel_o == 2'h0)
      else $error("ground mode with nonzero negative input");
   chk_diff_pairs: assert property (!negative_is_ground_o |->
      (negative_input_sel_o == 2'h3 && positive_input_sel_o != 2'h3) ||
      (negative_input_sel_o == 2'h1 && positive_input_sel_o == 2'h0))
      else $error("illegal differential pair");
   chk_idle_stable: assert property (cs_n_i[*6] |=> $stable(range_select_o) && $stable(rate_select_o))
      else $error("fields changed outside a frame");
endmodule // acr_adc_config_chk

bind acr_adc_config acr_adc_config_chk acr_adc_config_chk_i (.clk_i, .rst_i, .cs_n_i, .serial_out_ready_n_o,
   .serial_out_oe_o, .pullup_en_o, .conv_done_i, .conv_start_o, .continuous_o, .powered_down_o,
   .positive_input_sel_o, .negative_input_sel_o, .negative_is_ground_o, .range_select_o, .rate_select_o);

// ---- acr_spi_host.sv ----
module acr_spi_host (
   input  wire logic clk_i,   // Bench clock
   input  wire logic dout_i,  // Resolved data out line
   output logic      cs_n_o,  // Chip select
   output logic      sclk_o,  // Serial clock
   output logic      din_o    // Serial data to device
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half period of five cycles keeps sclk above the three-cycle minimum
   localparam int HALF = 5;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
   end
   // Mode 1: change on rise, sample on fall; sclk idles low between frames
   task automatic xfer(input logic [31:0] mosi, input int nbits, output logic [31:0] miso);
      miso = 32'h0000_0000;
      @(negedge clk_i) cs_n_o = 1'b0;
      repeat (HALF) @(negedge clk_i);
      for (int b = 0; b < nbits; b++) begin
         sclk_o = 1'b1;
         din_o = mosi[31-b];
         repeat (HALF) @(negedge clk_i);
         sclk_o = 1'b0;
         miso = {miso[30:0], dout_i};
         repeat (HALF) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
      repeat (2*HALF) @(negedge clk_i);
   endtask
endmodule // acr_spi_host

// ---- acr_adc_config_tb_top.sv ----
module acr_adc_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import acr_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, conv_done_i = 1'b0, cs_n_i, sclk_i, din_i, miso_w;
   logic        serial_out_ready_n_o, serial_out_oe_o, pullup_en_o, conv_start_o, continuous_o;
   logic        powered_down_o, negative_is_ground_o;
   logic [1:0]  positive_input_sel_o, negative_input_sel_o;
   logic [2:0]  range_select_o, rate_select_o, code;
   logic [15:0] conv_data_i = 16'h0000, exp_cfg, wd, res;
   logic [31:0] rd;
   integer      seed = 99, fail_count = 0, checks_done = 0, start_count = 0, exp_starts = 0;
   integer      busy_cnt = 0, conv_lat = 40;

   always #5 clk_i = ~clk_i;
   // Pull-up holds the line only when enabled; otherwise it floats
   assign miso_w = serial_out_oe_o ? serial_out_ready_n_o : (pullup_en_o ? 1'b1 : 1'bz);

   acr_adc_config acr_adc_config_i (.clk_i, .rst_i, .cs_n_i, .sclk_i, .din_i, .serial_out_ready_n_o,
      .serial_out_oe_o, .pullup_en_o, .conv_done_i, .conv_data_i, .conv_start_o, .continuous_o,
      .powered_down_o, .positive_input_sel_o, .negative_input_sel_o, .negative_is_ground_o,
      .range_select_o, .rate_select_o);
   acr_spi_host acr_spi_host_i (.clk_i, .dout_i(miso_w), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));

   // Analog side: finishes each started conversion after conv_lat cycles
   always @(negedge clk_i) begin
      conv_done_i <= 1'b0;
      if (conv_start_o === 1'b1) begin
         start_count++;
         busy_cnt = conv_lat;
      end else if (busy_cnt == 1) begin
         busy_cnt = 0;
         conv_done_i <= 1'b1;
         conv_data_i <= 16'($random(seed));
      end else if (busy_cnt > 1) busy_cnt--;
   end

   function automatic logic [4:0] exp_dec(input logic [2:0] m);
      if (m[2]) return {m[1:0], 2'h0, 1'b1};
      if (m == 3'h0) return {2'h0, 2'h1, 1'b0};
      return {m[1:0] - 2'h1, 2'h3, 1'b0};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_down();
      int n;
      n = 0;
      while (powered_down_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 2000) begin
         check(0, 1, "idle timeout");
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      check({range_select_o, rate_select_o, powered_down_o, continuous_o, pullup_en_o}, 9'h0A5, "reset");
      check({positive_input_sel_o, negative_input_sel_o, negative_is_ground_o}, exp_dec(3'h0), "mux");
      acr_spi_host_i.xfer(32'h0000_0000, 32, rd);
      check(rd, 32'h0000_058B, "reset readback");
      exp_cfg = ACR_CFG_RESET & ACR_CFG_WR_MASK;
      // Even passes commit every mux, span and rate code; odd passes try the same codes in reverse order with a random qualifier
      for (int i = 0; i < 16; i++) begin
         wd = 16'($random(seed));
         code = i[0] ? ~3'(i >> 1) : 3'(i >> 1);
         wd[14:12] = code;
         wd[7:5] = code;
         wd[11:9] = (code == 3'h7) ? 3'h6 : code;
         wd[8] = 1'b1;
         if (!i[0]) wd[2:1] = ACR_QUAL_COMMIT;
         if (wd[2:1] == ACR_QUAL_COMMIT) begin
            exp_cfg = wd & ACR_CFG_WR_MASK;
            exp_starts += wd[15];
         end
         res = conv_data_i;
         acr_spi_host_i.xfer({wd, wd}, 32, rd);
         wait_down();
         check(rd[15:0], exp_cfg | ACR_CFG_FIXED_ONE, "readback");
         check(rd[31:16], res, "result");
         check({range_select_o, rate_select_o, pullup_en_o}, {exp_cfg[11:9], exp_cfg[7:5], exp_cfg[3]}, "fields");
         check({positive_input_sel_o, negative_input_sel_o, negative_is_ground_o}, exp_dec(exp_cfg[14:12]), "pair");
         check(start_count, exp_starts, "starts");
      end
      // Trigger twice, the second landing mid-conversion
      conv_lat = 600;
      exp_starts++;
      repeat (2) acr_spi_host_i.xfer({16'h858B, 16'h0000}, 16, rd);
      check(powered_down_o, 1'b0, "busy");
      wait_down();
      repeat (50) @(negedge clk_i);
      check(powered_down_o, 1'b1, "back to idle");
      check(start_count, exp_starts, "one start");
      conv_lat = 30;
      acr_spi_host_i.xfer({16'h048B, 16'h0000}, 16, rd);
      repeat (100) @(negedge clk_i);
      check({continuous_o, powered_down_o}, 2'b10, "continuous");
      check(start_count > exp_starts + 1, 1, "restarts");
      acr_spi_host_i.xfer({16'h0583, 16'h0000}, 16, rd);
      wait_down();
      check({continuous_o, pullup_en_o}, 2'b00, "single, no pull-up");
      tally_and_finish();
   end
endmodule // acr_adc_config_tb_top
